// File: bench/iolc_pins.sv
`timescale 1ns/1ps
// Pins outside the port: driven lines read back, released lines follow the outside level
module iolc_pins (
  input  wire logic [31:0] pad_out,
  input  wire logic [31:0] pad_oe,
  input  wire logic [31:0] ext_lvl,
  output logic [31:0]      pad_in
);
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule : iolc_pins

// File: bench/iolc_port_monitor.sv
`timescale 1ns/1ps
module iolc_port_monitor
  import iolc_pkg::*;
#(
  parameter int          NUM_LINES   = 32,
  parameter logic [31:0] IMPL_MASK   = 32'hFFFFFFFF,
  parameter logic [31:0] PERIPH_MASK = 32'hFFFFFFFF
) (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic                   ce,
  input wire logic                   hsel,
  input wire logic [IOLC_ADDR_W-1:0] haddr,
  input wire logic [1:0]             htrans,
  input wire logic                   hwrite,
  input wire logic [2:0]             hsize,
  input wire logic [IOLC_DATA_W-1:0] hwdata,
  input wire logic                   hready,
  input wire logic                   hreadyout,
  input wire logic                   hresp,
  input wire logic [IOLC_DATA_W-1:0] hrdata,
  input wire logic [NUM_LINES-1:0]   pad_in,
  input wire logic [NUM_LINES-1:0]   pad_out,
  input wire logic [NUM_LINES-1:0]   pad_oe,
  input wire logic [NUM_LINES-1:0]   periph_out,
  input wire logic [NUM_LINES-1:0]   periph_oe,
  input wire logic [NUM_LINES-1:0]   periph_in
);
  localparam logic [31:0] FIX = ~PERIPH_MASK & IMPL_MASK;
  localparam logic [31:0] PX  = PERIPH_MASK & IMPL_MASK;
  wire       acc    = hsel & hready & htrans[1] & ce;
  wire       rd_acc = acc & ~hwrite;
  logic       wq;
  logic [7:0] wa;
  // Data phase of an accepted word write
  always_ff @(posedge mclk) begin
    if (rst) begin
      wq <= 1'b0;
    end else if (ce) begin
      wq <= acc & hwrite & (hsize == IOLC_HSIZE_WORD);
      wa <= haddr;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_oe_set_drives: assert property (wq && ce && wa == IOLC_OUT_EN_SET |=> (~pad_oe & FIX & $past(hwdata)) == 0)
    else $error("output driver not on after enable");
  a_oe_clr_release: assert property (wq && ce && wa == IOLC_OUT_EN_CLR |=> (pad_oe & ~periph_oe & IMPL_MASK & $past(hwdata)) == 0)
    else $error("output driver still on after disable");
  a_data_set_high: assert property (wq && ce && wa == IOLC_DATA_SET |=> ((pad_out ^ pad_oe) & FIX & $past(hwdata)) == 0)
    else $error("owned line not high after set");
  a_data_clr_low: assert property (wq && ce && wa == IOLC_DATA_CLR |=> (pad_out & ~periph_out & IMPL_MASK & $past(hwdata)) == 0)
    else $error("line not low after clear");
  a_handover_pass: assert property (wq && ce && wa == IOLC_LINE_CTL_DIS |=>
    (((pad_oe ^ periph_oe) | (pad_out ^ periph_out)) & PX & $past(hwdata)) == 0)
    else $error("peripheral not passed through");
  a_unimpl_zero: assert property (rd_acc |=> (hrdata & ~IMPL_MASK) == 0)
    else $error("unimplemented bit reads one");
  a_fixed_owner: assert property (rd_acc && haddr == IOLC_LINE_CTL_STAT |=> (hrdata & FIX) == FIX)
    else $error("line without peripheral not owned");
  a_reset_idle: assert property (disable iff (1'b0) rst |=> (pad_oe & IMPL_MASK) == 0 && hrdata == 0)
    else $error("pads or read data busy after reset");
  a_bus_ready_ok: assert property (hreadyout == ce && hresp == IOLC_HRESP_OKAY)
    else $error("bus ready or response wrong");
  c_data_set: cover property (wq && ce && wa == IOLC_DATA_SET);
  c_pin_read: cover property (rd_acc && haddr == IOLC_PIN_STAT);
  c_frozen: cover property (!ce);
endmodule : iolc_port_monitor

bind iolc_port iolc_port_monitor #(.NUM_LINES(NUM_LINES), .IMPL_MASK(IMPL_MASK), .PERIPH_MASK(PERIPH_MASK)) u_mon (
  .mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe(pad_oe), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in));

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
  import iolc_pkg::*;
  localparam logic [31:0] IM = 32'h7FFFFFFF;
  localparam logic [31:0] PM = 32'hFFFF00FF;
  logic        mclk = 0, rst = 1, ce = 1, hsel = 0, hwrite = 0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, periph_out = 32'h3C3C3C3C, periph_oe = 32'hA5A5A5A5, ext = 32'h12345678;
  logic [31:0] own = IM, oe = 32'h0, dat = 32'h0, v, pin_e;
  wire         hreadyout, hresp;
  wire  [31:0] hrdata, pad_in, pad_out, pad_oe, periph_in;
  int          bad_count = 0, n_compared = 0, cyc = 0;
  iolc_port #(.NUM_LINES(32), .IMPL_MASK(IM), .PERIPH_MASK(PM)) DUT (
    .mclk(mclk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in));
  iolc_pins u_pins (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext), .pad_in(pad_in));
  initial forever #50 mclk = ~mclk;
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      finish_test;
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [2:0] sz);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= IOLC_HTRANS_NONSEQ;
    hwrite <= w;
    hsize <= sz;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, IOLC_HSIZE_WORD);
  endtask : wr
  task rc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0, IOLC_HSIZE_WORD);
    chk($sformatf("reg_%h", a), v, e);
  endtask : rc
  // Pads and pin levels against the shadow state
  task pads;
    logic [31:0] eo, ed;
    repeat (3) @(posedge mclk);
    eo = ((own & oe) | (~own & periph_oe)) & IM;
    ed = ((own & oe & dat) | (~own & periph_out)) & IM;
    pin_e = ((eo & ed) | (~eo & ext)) & IM;
    chk("pad_oe", pad_oe & IM, eo);
    chk("pad_out", pad_out & IM, ed);
    rc(IOLC_PIN_STAT, pin_e);
    chk("periph_in", periph_in, pin_e);
  endtask : pads
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rc(IOLC_LINE_CTL_STAT, IM);
    rc(IOLC_OUT_EN_STAT, IOLC_ZERO);
    rc(IOLC_FILT_STAT, IOLC_ZERO);
    rc(8'h0C, IOLC_ZERO);
    pads;
    wr(IOLC_LINE_CTL_DIS, 32'hFFFFFFFF);
    own = ~PM & IM;
    rc(IOLC_LINE_CTL_STAT, own);
    pads;
    wr(IOLC_LINE_CTL_EN, 32'h0000000F);
    own = own | 32'h0000000F;
    rc(IOLC_LINE_CTL_STAT, own);
    wr(IOLC_OUT_EN_SET, 32'h0000FFFF);
    wr(IOLC_OUT_EN_CLR, 32'h000000F0);
    bus(IOLC_OUT_EN_SET, 1'b1, 32'hFFFF0000, 3'h1);
    oe = 32'h0000FF0F;
    rc(IOLC_OUT_EN_STAT, oe);
    wr(IOLC_FILT_EN, 32'h80000F00);
    wr(IOLC_FILT_DIS, 32'h00000300);
    rc(IOLC_FILT_STAT, 32'h00000C00);
    wr(IOLC_DATA_SET, 32'h8000A50F);
    wr(IOLC_DATA_CLR, 32'h0000000A);
    dat = 32'h0000A505;
    rc(IOLC_DATA_STAT, dat);
    pads;
    wr(IOLC_DATA_STAT, 32'hFFFFFFFF);
    rc(IOLC_DATA_STAT, dat);
    wr(IOLC_OWR_EN, 32'h000000FF);
    wr(IOLC_DATA_STAT, 32'h00000000);
    dat = 32'h0000A500;
    rc(IOLC_DATA_STAT, dat);
    ext <= 32'h5A5A5A5A;
    pads;
    ce <= 1'b0;
    ext <= 32'hA5A5A5A5;
    repeat (3) @(posedge mclk);
    chk("periph_in", periph_in, pin_e);
    ce <= 1'b1;
    pads;
    wr(IOLC_FILT_EN, 32'h00000010);
    repeat (3) @(posedge mclk);
    v = periph_in;
    ext <= ext ^ 32'h00000010;
    @(posedge mclk);
    ext <= ext ^ 32'h00000010;
    repeat (3) begin
      @(posedge mclk);
      chk("glitch_line4", periph_in & 32'h00000010, v & 32'h00000010);
    end
    finish_test;
  end
endmodule : tb

// File: common/iolc_pkg.sv
package iolc_pkg;

  localparam int          IOLC_DATA_W        = 32;
  localparam int          IOLC_ADDR_W        = 8;

  // Register byte offsets
  localparam logic [7:0]  IOLC_LINE_CTL_EN   = 8'h00;
  localparam logic [7:0]  IOLC_LINE_CTL_DIS  = 8'h04;
  localparam logic [7:0]  IOLC_LINE_CTL_STAT = 8'h08;
  localparam logic [7:0]  IOLC_OUT_EN_SET    = 8'h10;
  localparam logic [7:0]  IOLC_OUT_EN_CLR    = 8'h14;
  localparam logic [7:0]  IOLC_OUT_EN_STAT   = 8'h18;
  localparam logic [7:0]  IOLC_FILT_EN       = 8'h20;
  localparam logic [7:0]  IOLC_FILT_DIS      = 8'h24;
  localparam logic [7:0]  IOLC_FILT_STAT     = 8'h28;
  localparam logic [7:0]  IOLC_DATA_SET      = 8'h30;
  localparam logic [7:0]  IOLC_DATA_CLR      = 8'h34;
  localparam logic [7:0]  IOLC_DATA_STAT     = 8'h38;
  localparam logic [7:0]  IOLC_PIN_STAT      = 8'h3C;
  localparam logic [7:0]  IOLC_OWR_EN        = 8'hA0;
  localparam logic [7:0]  IOLC_OWR_DIS       = 8'hA4;
  localparam logic [7:0]  IOLC_OWR_STAT      = 8'hA8;

  // Reset values
  localparam logic [31:0] IOLC_LINE_CTL_RST  = 32'hFFFFFFFF;
  localparam logic [31:0] IOLC_OUT_EN_RST    = 32'h00000000;
  localparam logic [31:0] IOLC_FILT_RST      = 32'h00000000;
  localparam logic [31:0] IOLC_DATA_RST      = 32'h00000000;
  localparam logic [31:0] IOLC_OWR_RST       = 32'h00000000;
  localparam logic [31:0] IOLC_ZERO          = 32'h00000000;

  // AHB-Lite encodings
  localparam logic [1:0]  IOLC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  IOLC_HTRANS_SEQ    = 2'h3;
  localparam logic [2:0]  IOLC_HSIZE_WORD    = 3'h2;
  localparam logic        IOLC_HRESP_OKAY    = 1'b0;

endpackage : iolc_pkg

// File: hdl/iolc_port.sv
// Design decisions made here: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Behaviour
// - Writing 1 to line_control_enable gives the line to the controller.
// - Writing 1 to line_control_disable hands the line to the peripheral.
// - line_control_status reads 1 for controller-owned lines, 0 for peripheral lines.
// - Writing 1 to output_enable_set turns on that line's driver.
// - Writing 1 to output_enable_clear turns off that line's driver.
// - output_enable_status reads 1 for driven lines, 0 for pure inputs.
// - Writing 1 to glitch_filter_enable switches on that line's filter.
// - Writing 1 to glitch_filter_disable switches off that line's filter.
// - glitch_filter_status reads 1 where the filter is active.
// - Writing 1 to output_data_set makes the line's drive level high.
// - Writing 1 to output_data_clear makes the line's drive level low.
// - output_data_status reads the intended drive level per line.
// - output_data_status is read-only or writable, chosen per line.
// - pin_level_status returns the real level on each line.
// - Direct output_data_status writes only change lines with write permission.
// - Unimplemented lines ignore writes and read zero everywhere.
// - Lines without a peripheral always read 1 in line_control_status.
// - pin_level_status holds its sampled levels while the clock is stopped.
module iolc_port
  import iolc_pkg::*;
#(
  parameter int          NUM_LINES   = 32,
  parameter logic [31:0] IMPL_MASK   = 32'hFFFFFFFF,
  parameter logic [31:0] PERIPH_MASK = 32'hFFFFFFFF
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire logic                   hsel,
  input  wire logic [IOLC_ADDR_W-1:0] haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [IOLC_DATA_W-1:0] hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [IOLC_DATA_W-1:0]      hrdata,
  input  wire logic [NUM_LINES-1:0]   pad_in,
  output logic [NUM_LINES-1:0]        pad_out,
  output logic [NUM_LINES-1:0]        pad_oe,
  input  wire logic [NUM_LINES-1:0]   periph_out,
  input  wire logic [NUM_LINES-1:0]   periph_oe,
  output logic [NUM_LINES-1:0]        periph_in
);

  localparam logic [NUM_LINES-1:0] IMPL   = IMPL_MASK[NUM_LINES-1:0];
  localparam logic [NUM_LINES-1:0] PERIPH = PERIPH_MASK[NUM_LINES-1:0];

  // Apply one-hot set and clear strobes to a per-line state word
  function automatic logic [NUM_LINES-1:0] set_clear(
    input logic [NUM_LINES-1:0] cur,
    input logic                 do_set,
    input logic                 do_clr,
    input logic [NUM_LINES-1:0] bits
  );
    logic [NUM_LINES-1:0] res;
    res = cur;
    if (do_set) begin
      res = res | (bits & IMPL);
    end
    if (do_clr) begin
      res = res & ~(bits & IMPL);
    end
    return res;
  endfunction : set_clear

  // Widen a per-line word to the bus width, upper bits zero
  function automatic logic [IOLC_DATA_W-1:0] to_bus(input logic [NUM_LINES-1:0] v);
    logic [IOLC_DATA_W-1:0] res;
    res = IOLC_ZERO;
    res[NUM_LINES-1:0] = v & IMPL;
    return res;
  endfunction : to_bus

  // True in the data phase of an accepted word write to the given offset
  function automatic logic wr_hit(
    input logic                   wr,
    input logic [IOLC_ADDR_W-1:0] addr,
    input logic [IOLC_ADDR_W-1:0] off
  );
    return wr && (addr == off);
  endfunction : wr_hit

  // Bus data-phase state
  logic                   dp_wr_reg;
  logic [IOLC_ADDR_W-1:0] dp_addr_reg;
  logic [IOLC_DATA_W-1:0] hrdata_reg;

  // Per-line state
  logic [NUM_LINES-1:0]   line_ctl_reg;
  logic [NUM_LINES-1:0]   out_en_reg;
  logic [NUM_LINES-1:0]   filt_en_reg;
  logic [NUM_LINES-1:0]   out_data_reg;
  logic [NUM_LINES-1:0]   owr_reg;
  logic [NUM_LINES-1:0]   pin_samp_reg;
  logic [NUM_LINES-1:0]   pin_level_reg;

  logic [NUM_LINES-1:0]   line_ctl_next;
  logic [NUM_LINES-1:0]   out_en_next;
  logic [NUM_LINES-1:0]   filt_en_next;
  logic [NUM_LINES-1:0]   out_data_next;
  logic [NUM_LINES-1:0]   owr_next;
  logic [NUM_LINES-1:0]   pin_level_next;
  logic [IOLC_DATA_W-1:0] hrdata_next;

  wire                    ap_valid;
  wire                    ap_read;
  wire                    ap_write;
  wire [NUM_LINES-1:0]    wbits;
  wire                    wr_lc_en;
  wire                    wr_lc_dis;
  wire                    wr_oe_set;
  wire                    wr_oe_clr;
  wire                    wr_flt_en;
  wire                    wr_flt_dis;
  wire                    wr_d_set;
  wire                    wr_d_clr;
  wire                    wr_d_stat;
  wire                    wr_ow_en;
  wire                    wr_ow_dis;
  wire [NUM_LINES-1:0]    owned;
  wire [NUM_LINES-1:0]    line_ctl_view;
  wire [NUM_LINES-1:0]    line_ctl_view_next;
  wire [NUM_LINES-1:0]    stable;

  // Address phase decode
  assign ap_valid = hsel && hready && (htrans == IOLC_HTRANS_NONSEQ || htrans == IOLC_HTRANS_SEQ);
  assign ap_write = ap_valid && hwrite && (hsize == IOLC_HSIZE_WORD);
  assign ap_read  = ap_valid && !hwrite;

  // Data phase write strobes
  assign wbits      = hwdata[NUM_LINES-1:0];
  assign wr_lc_en   = wr_hit(dp_wr_reg, dp_addr_reg, IOLC_LINE_CTL_EN);
  assign wr_lc_dis  = wr_hit(dp_wr_reg, dp_addr_reg, IOLC_LINE_CTL_DIS);
  assign wr_oe_set  = wr_hit(dp_wr_reg, dp_addr_reg, IOLC_OUT_EN_SET);
  assign wr_oe_clr  = wr_hit(dp_wr_reg, dp_addr_reg, IOLC_OUT_EN_CLR);
  assign wr_flt_en  = wr_hit(dp_wr_reg, dp_addr_reg, IOLC_FILT_EN);
  assign wr_flt_dis = wr_hit(dp_wr_reg, dp_addr_reg, IOLC_FILT_DIS);
  assign wr_d_set   = wr_hit(dp_wr_reg, dp_addr_reg, IOLC_DATA_SET);
  assign wr_d_clr   = wr_hit(dp_wr_reg, dp_addr_reg, IOLC_DATA_CLR);
  assign wr_d_stat  = wr_hit(dp_wr_reg, dp_addr_reg, IOLC_DATA_STAT);
  assign wr_ow_en   = wr_hit(dp_wr_reg, dp_addr_reg, IOLC_OWR_EN);
  assign wr_ow_dis  = wr_hit(dp_wr_reg, dp_addr_reg, IOLC_OWR_DIS);

  // Next state of the per-line control words
  always_comb begin
    line_ctl_next = set_clear(line_ctl_reg, wr_lc_en, wr_lc_dis, wbits);
    out_en_next   = set_clear(out_en_reg, wr_oe_set, wr_oe_clr, wbits);
    filt_en_next  = set_clear(filt_en_reg, wr_flt_en, wr_flt_dis, wbits);
    owr_next      = set_clear(owr_reg, wr_ow_en, wr_ow_dis, wbits);
    out_data_next = set_clear(out_data_reg, wr_d_set, wr_d_clr, wbits);
    if (wr_d_stat) begin
      out_data_next = (out_data_reg & ~(owr_reg & IMPL)) | (wbits & owr_reg & IMPL);
    end
  end

  // Lines with no peripheral are permanently owned by the controller
  assign line_ctl_view      = (line_ctl_reg | ~PERIPH) & IMPL;
  assign line_ctl_view_next = (line_ctl_next | ~PERIPH) & IMPL;
  assign owned              = line_ctl_view;

  // Glitch filter: a filtered line accepts a level once it holds two samples
  assign stable = ~(pad_in ^ pin_samp_reg);
  always_comb begin
    pin_level_next = (pad_in & ~filt_en_reg) | (pin_level_reg & filt_en_reg & ~stable)
                   | (pad_in & filt_en_reg & stable);
  end

  // Read data uses next values so a write is visible to the read right after it
  always_comb begin
    hrdata_next = IOLC_ZERO;
    if (ap_read) begin
      unique case (haddr)
        IOLC_LINE_CTL_STAT: hrdata_next = to_bus(line_ctl_view_next);
        IOLC_OUT_EN_STAT:   hrdata_next = to_bus(out_en_next);
        IOLC_FILT_STAT:     hrdata_next = to_bus(filt_en_next);
        IOLC_DATA_STAT:     hrdata_next = to_bus(out_data_next);
        IOLC_PIN_STAT:      hrdata_next = to_bus(pin_level_next);
        IOLC_OWR_STAT:      hrdata_next = to_bus(owr_next);
        default:            hrdata_next = IOLC_ZERO;
      endcase
    end
  end

  // Bus slave registers; a low clock enable freezes everything
  always_ff @(posedge mclk) begin
    if (rst) begin
      dp_wr_reg   <= 1'b0;
      dp_addr_reg <= '0;
      hrdata_reg  <= IOLC_ZERO;
    end else if (ce) begin
      dp_wr_reg   <= ap_write;
      dp_addr_reg <= haddr;
      hrdata_reg  <= hrdata_next;
    end
  end

  // Line state registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      line_ctl_reg <= IOLC_LINE_CTL_RST[NUM_LINES-1:0];
      out_en_reg   <= IOLC_OUT_EN_RST[NUM_LINES-1:0];
      filt_en_reg  <= IOLC_FILT_RST[NUM_LINES-1:0];
      out_data_reg <= IOLC_DATA_RST[NUM_LINES-1:0];
      owr_reg      <= IOLC_OWR_RST[NUM_LINES-1:0];
    end else if (ce) begin
      line_ctl_reg <= line_ctl_next;
      out_en_reg   <= out_en_next;
      filt_en_reg  <= filt_en_next;
      out_data_reg <= out_data_next;
      owr_reg      <= owr_next;
    end
  end

  // Pin sampling stops with the clock enable, holding the last levels
  always_ff @(posedge mclk) begin
    if (rst) begin
      pin_samp_reg  <= '0;
      pin_level_reg <= '0;
    end else if (ce) begin
      pin_samp_reg  <= pad_in;
      pin_level_reg <= pin_level_next;
    end
  end

  // Per-line pad multiplexer
  for (genvar i = 0; i < NUM_LINES; i++) begin : g_pad
    if (IMPL[i]) begin : g_impl
      assign pad_oe[i]  = owned[i] ? out_en_reg[i] : periph_oe[i];
      assign pad_out[i] = owned[i] ? (out_en_reg[i] & out_data_reg[i]) : periph_out[i];
    end else begin : g_none
      assign pad_oe[i]  = 1'b0;
      assign pad_out[i] = 1'b0;
    end
  end

  assign periph_in = pin_level_reg & IMPL;
  assign hreadyout = ce;
  assign hresp     = IOLC_HRESP_OKAY;
  assign hrdata    = hrdata_reg;

endmodule : iolc_port
